// [pkg/uoc_cfg.svh]
// Purpose: constants for the otg session and role control block
// Assumes: 25 MHz core clock, AXI4-Lite register access
// Notes: offsets are byte addresses, fields are bit positions
`ifndef UOC_CFG_SVH
`define UOC_CFG_SVH
`define UOC_CLK_HZ 25000000
// register byte offsets
`define UOC_OFF_CTRL 12'h000
`define UOC_OFF_STAT 12'h004
`define UOC_OFF_LATCH 12'h008
`define UOC_OFF_ENFALL 12'h00C
`define UOC_OFF_ENRISE 12'h010
`define UOC_OFF_TIMER 12'h014
`define UOC_OFF_PEVT 12'h018
`define UOC_OFF_PEVTEN 12'h01C
// control fields
`define UOC_CTL_PULLUP 0
`define UOC_CTL_DISCHG 5
`define UOC_CTL_CHARGE 6
`define UOC_CTL_SRPGO 8
`define UOC_CTL_BUSDRV 9
`define UOC_CTL_DRVRST 11
`define UOC_CTL_HNPGO 12
// status fields
`define UOC_ST_PLUG 0
`define UOC_ST_SVALID 1
`define UOC_ST_DPPULSE 2
`define UOC_ST_IDLE3 3
`define UOC_ST_HOST 4
`define UOC_ST_SEND 7
`define UOC_ST_SE0 8
`define UOC_ST_SRPDONE 9
`define UOC_ST_SRPERR 10
`define UOC_ST_TMO 11
// latch bit of timer timeout
`define UOC_LT_TMO 4
// peripheral event suspend flag
`define UOC_PE_SUSP 0
// timing in microseconds, tick period in nanoseconds
`define UOC_PULSE_DP_US 7000
`define UOC_PULSE_VB_US 15000
`define UOC_DRAIN_US 30000
`define UOC_SRP_MAX_US 100000
`define UOC_IDLE_B_US 5000
`define UOC_IDLE_A_US 3000
`define UOC_SETTLE_US 30
`define UOC_TICK_NS 10000
`define UOC_US_CYC(us) (((us) * (`UOC_CLK_HZ / 1000000)))
`define UOC_TICK_CYC ((`UOC_TICK_NS * (`UOC_CLK_HZ / 1000000)) / 1000)
`endif

// [pkg/uoc_pkg.sv]
// Purpose: types for the otg session and role control block
// Assumes: nothing beyond the config header
// Notes: states only
package uoc_pkg;
  typedef enum logic [2:0] {
    UOC_SRP_IDLE, UOC_SRP_DP, UOC_SRP_VB, UOC_SRP_DRAIN
  } uoc_srp_t;
  typedef enum logic [2:0] {
    UOC_HNP_IDLE, UOC_HNP_B_WAIT, UOC_HNP_B_SETTLE, UOC_HNP_A_SE0,
    UOC_HNP_A_PERI, UOC_HNP_A_SETTLE
  } uoc_hnp_t;
endpackage

// [rtl/uoc_top.sv]
// Purpose: otg dual-role session request and host hand-off control
// Assumes: line status pins asynchronous; software runs the otg sequence
// Notes: control register uses a set half (low 16) and clear half (high 16)
`timescale 1ns/1ns
`include "uoc_cfg.svh"

module uoc_top import uoc_pkg::*; #(
  parameter int unsigned DP_CYC = `UOC_US_CYC(`UOC_PULSE_DP_US),
  parameter int unsigned VB_CYC = `UOC_US_CYC(`UOC_PULSE_VB_US),
  parameter int unsigned DRAIN_CYC = `UOC_US_CYC(`UOC_DRAIN_US),
  parameter int unsigned SRPMAX_CYC = `UOC_US_CYC(`UOC_SRP_MAX_US),
  parameter int unsigned IDLEB_CYC = `UOC_US_CYC(`UOC_IDLE_B_US),
  parameter int unsigned IDLEA_CYC = `UOC_US_CYC(`UOC_IDLE_A_US),
  parameter int unsigned SETTLE_CYC = `UOC_US_CYC(`UOC_SETTLE_US),
  parameter int unsigned TICK_CYC = `UOC_TICK_CYC
) (
  // clock and reset
  input wire logic i_core_clk,
  input wire logic i_rst,
  // axi4-lite write
  input wire logic [11:0] i_awaddr,
  input wire logic i_awvalid,
  output logic o_awready,
  input wire logic [31:0] i_wdata,
  input wire logic [3:0] i_wstrb,
  input wire logic i_wvalid,
  output logic o_wready,
  output logic [1:0] o_bresp,
  output logic o_bvalid,
  input wire logic i_bready,
  // axi4-lite read
  input wire logic [11:0] i_araddr,
  input wire logic i_arvalid,
  output logic o_arready,
  output logic [31:0] o_rdata,
  output logic [1:0] o_rresp,
  output logic o_rvalid,
  input wire logic i_rready,
  // line and plug sense, asynchronous
  input wire logic i_plug_type_sense,
  input wire logic i_sess_valid,
  input wire logic i_sess_end,
  input wire logic i_line_dp,
  input wire logic i_line_dm,
  input wire logic i_bus_activity,
  // analog controls
  output logic o_data_plus_pull_up,
  output logic o_bus_power_charge,
  output logic o_bus_power_drain,
  output logic o_charge_pump_en,
  output logic o_bus_reset_drive,
  output logic o_host_role
);

  // synchronisers: stage one read only by stage two
  logic [5:0] sy1_r, sy2_r, prev_r;
  always_ff @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      sy1_r <= 6'h00;
      sy2_r <= 6'h00;
      prev_r <= 6'h00;
    end else begin
      sy1_r <= {i_bus_activity, i_line_dm, i_line_dp, i_sess_end,
                i_sess_valid, i_plug_type_sense};
      sy2_r <= sy1_r;
      prev_r <= sy2_r;
    end
  end
  wire plug_s = sy2_r[0];
  wire svalid_s = sy2_r[1];
  wire send_s = sy2_r[2];
  wire dp_s = sy2_r[3];
  wire dm_s = sy2_r[4];
  wire act_s = sy2_r[5];
  wire se0_s = !dp_s && !dm_s;
  wire j_s = dp_s && !dm_s;
  wire is_a = !plug_s;
  wire dp_rise = dp_s && !prev_r[3];

  // registers
  logic [15:0] ctrl_r, latch_r, enf_r, enr_r, pevt_r, pevten_r;
  logic [31:0] tmr_load_r, tmr_cnt_r;
  logic tmo_r, srp_done_r, srp_err_r, host_r, pup_hw_r, pup_hw_on_r;
  logic idle3_r;

  // axi4-lite slave, one write and one read at a time
  logic aw_have_r, w_have_r;
  logic [11:0] aw_addr_r;
  logic [31:0] w_data_r;
  logic [3:0] w_strb_r;
  wire wr_go = aw_have_r && w_have_r && !o_bvalid;
  always_ff @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      aw_have_r <= 1'b0;
      w_have_r <= 1'b0;
      aw_addr_r <= 12'h000;
      w_data_r <= 32'h0000_0000;
      w_strb_r <= 4'h0;
      o_bvalid <= 1'b0;
    end else begin
      if (i_awvalid && o_awready) begin
        aw_have_r <= 1'b1;
        aw_addr_r <= i_awaddr;
      end
      if (i_wvalid && o_wready) begin
        w_have_r <= 1'b1;
        w_data_r <= i_wdata;
        w_strb_r <= i_wstrb;
      end
      if (wr_go) begin
        aw_have_r <= 1'b0;
        w_have_r <= 1'b0;
        o_bvalid <= 1'b1;
      end else if (o_bvalid && i_bready) begin
        o_bvalid <= 1'b0;
      end
    end
  end
  assign o_awready = !aw_have_r && !o_bvalid;
  assign o_wready = !w_have_r && !o_bvalid;
  assign o_bresp = 2'h0;
  wire [15:0] set_h = {{8{w_strb_r[1]}}, {8{w_strb_r[0]}}} & w_data_r[15:0];
  wire [15:0] clr_h = {{8{w_strb_r[3]}}, {8{w_strb_r[2]}}}
                      & w_data_r[31:16];
  function automatic logic [15:0] setclr(input logic [15:0] cur,
      input logic hit, input logic [15:0] s, input logic [15:0] c);
    setclr = hit ? ((cur & ~c) | s) : cur;
  endfunction
  wire wr_ctrl = wr_go && aw_addr_r == `UOC_OFF_CTRL;
  wire wr_latch = wr_go && aw_addr_r == `UOC_OFF_LATCH;
  wire wr_pevt = wr_go && aw_addr_r == `UOC_OFF_PEVT;

  // edge detection into latch; edges recorded only if enabled, timer timeout always
  logic [15:0] rise_v, fall_v, stat_v;
  always_comb begin
    stat_v = 16'h0000;
    stat_v[`UOC_ST_PLUG] = plug_s;
    stat_v[`UOC_ST_SVALID] = svalid_s;
    stat_v[`UOC_ST_DPPULSE] = dp_s && !o_data_plus_pull_up;
    stat_v[`UOC_ST_IDLE3] = idle3_r;
    stat_v[`UOC_ST_HOST] = host_r;
    stat_v[`UOC_ST_SEND] = send_s;
    stat_v[`UOC_ST_SE0] = se0_s;
    stat_v[`UOC_ST_SRPDONE] = srp_done_r;
    stat_v[`UOC_ST_SRPERR] = srp_err_r;
    stat_v[`UOC_ST_TMO] = tmo_r;
    rise_v = 16'h0000;
    fall_v = 16'h0000;
    rise_v[`UOC_ST_SVALID] = svalid_s && !prev_r[1];
    fall_v[`UOC_ST_SVALID] = !svalid_s && prev_r[1];
    rise_v[`UOC_ST_DPPULSE] = dp_rise && !o_data_plus_pull_up;
  end
  // set wins over clear for every latch bit
  always_ff @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      latch_r <= 16'h0000;
    end else begin
      latch_r <= setclr(latch_r, wr_latch, set_h, clr_h)
                 | (rise_v & enr_r) | (fall_v & enf_r)
                 | {11'h000, tmo_r, 4'h0};
    end
  end

  // enable registers
  always_ff @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      enf_r <= 16'h0000;
      enr_r <= 16'h0000;
      pevten_r <= 16'h0000;
    end else begin
      enf_r <= setclr(enf_r, wr_go && aw_addr_r == `UOC_OFF_ENFALL,
                      set_h, clr_h);
      enr_r <= setclr(enr_r, wr_go && aw_addr_r == `UOC_OFF_ENRISE,
                      set_h, clr_h);
      pevten_r <= setclr(pevten_r, wr_go && aw_addr_r == `UOC_OFF_PEVTEN,
                         set_h, clr_h);
    end
  end

  // control register: software bits, request bits self-clear
  uoc_srp_t srp_r;
  uoc_hnp_t hnp_r;
  always_ff @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      ctrl_r <= 16'h0000;
    end else begin
      ctrl_r <= setclr(ctrl_r, wr_ctrl, set_h, clr_h);
      if (!is_a) begin
        ctrl_r[`UOC_CTL_BUSDRV] <= 1'b0;
      end
      // one-cycle strobe: a refused request must not stay armed
      if (ctrl_r[`UOC_CTL_SRPGO]) begin
        ctrl_r[`UOC_CTL_SRPGO] <= 1'b0;
      end
      if (hnp_r != UOC_HNP_IDLE) begin
        ctrl_r[`UOC_CTL_HNPGO] <= 1'b0;
      end
    end
  end

  // 0.01 ms tick and programmable down timer
  logic [15:0] tick_r;
  wire tick = tick_r == 16'(TICK_CYC - 1);
  wire wr_tmr = wr_go && aw_addr_r == `UOC_OFF_TIMER;
  always_ff @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      tick_r <= 16'h0000;
      tmr_load_r <= 32'h0000_0000;
      tmr_cnt_r <= 32'h0000_0000;
      tmo_r <= 1'b0;
    end else begin
      tick_r <= tick ? 16'h0000 : tick_r + 16'h0001;
      tmo_r <= 1'b0;
      if (wr_tmr) begin
        tmr_load_r <= w_data_r;
        tmr_cnt_r <= w_data_r;
      end else if (tick && tmr_cnt_r != 32'h0000_0000) begin
        tmr_cnt_r <= tmr_cnt_r - 32'h0000_0001;
        tmo_r <= tmr_cnt_r == 32'h0000_0001;
      end
    end
  end

  // session request sequencer for the B role
  logic [31:0] srp_cnt_r, srp_tot_r;
  always_ff @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      srp_r <= UOC_SRP_IDLE;
      srp_cnt_r <= 32'h0000_0000;
      srp_tot_r <= 32'h0000_0000;
      srp_done_r <= 1'b0;
      srp_err_r <= 1'b0;
    end else begin
      srp_cnt_r <= srp_cnt_r + 32'h0000_0001;
      if (srp_r != UOC_SRP_IDLE) begin
        srp_tot_r <= srp_tot_r + 32'h0000_0001;
      end
      case (srp_r)
        UOC_SRP_IDLE: begin
          if (ctrl_r[`UOC_CTL_SRPGO] && !is_a) begin
            srp_done_r <= 1'b0;
            srp_err_r <= !(send_s && se0_s);
            srp_cnt_r <= 32'h0000_0000;
            srp_tot_r <= 32'h0000_0000;
            if (send_s && se0_s) begin
              srp_r <= UOC_SRP_DP;
            end
          end
        end
        UOC_SRP_DP: begin
          if (srp_cnt_r == DP_CYC - 1) begin
            srp_cnt_r <= 32'h0000_0000;
            srp_r <= UOC_SRP_VB;
          end
        end
        UOC_SRP_VB: begin
          if (srp_cnt_r == VB_CYC - 1) begin
            srp_cnt_r <= 32'h0000_0000;
            srp_err_r <= srp_tot_r >= SRPMAX_CYC;
            srp_done_r <= !ctrl_r[`UOC_CTL_DISCHG];
            srp_r <= ctrl_r[`UOC_CTL_DISCHG] ? UOC_SRP_DRAIN
                     : UOC_SRP_IDLE;
          end
        end
        UOC_SRP_DRAIN: begin
          if (srp_cnt_r == DRAIN_CYC - 1) begin
            srp_done_r <= 1'b1;
            srp_r <= UOC_SRP_IDLE;
          end
        end
        default: srp_r <= UOC_SRP_IDLE;
      endcase
    end
  end

  // bus idle counter, restarted by any activity
  logic [31:0] idle_r;
  always_ff @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      idle_r <= 32'h0000_0000;
      idle3_r <= 1'b0;
    end else begin
      idle_r <= (act_s || !se0_s && !j_s) ? 32'h0000_0000
                : idle_r + {31'h0, idle_r != 32'hFFFF_FFFF};
      idle3_r <= idle_r >= IDLEA_CYC;
    end
  end

  // host hand-off sequencer
  logic [31:0] hcnt_r;
  always_ff @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      hnp_r <= UOC_HNP_IDLE;
      hcnt_r <= 32'h0000_0000;
      pup_hw_r <= 1'b0;
      pup_hw_on_r <= 1'b0;
      host_r <= 1'b0;
    end else begin
      hcnt_r <= hcnt_r + 32'h0000_0001;
      case (hnp_r)
        UOC_HNP_IDLE: begin
          pup_hw_r <= 1'b0;
          // default role from the plug; A hosts once B connects
          host_r <= is_a && j_s;
          if (ctrl_r[`UOC_CTL_HNPGO]) begin
            // software sent the enable request and suspended the bus
            hnp_r <= is_a ? UOC_HNP_A_SE0 : UOC_HNP_B_WAIT;
          end
        end
        UOC_HNP_B_WAIT: begin
          pup_hw_r <= 1'b1;
          pup_hw_on_r <= 1'b1;
          if (idle_r > IDLEB_CYC) begin
            pup_hw_on_r <= 1'b0;
            hcnt_r <= 32'h0000_0000;
            hnp_r <= UOC_HNP_B_SETTLE;
          end
        end
        UOC_HNP_B_SETTLE: begin
          if (hcnt_r >= SETTLE_CYC && j_s) begin
            host_r <= 1'b1;
            hnp_r <= UOC_HNP_IDLE;
          end
        end
        UOC_HNP_A_SE0: begin
          if (se0_s) begin
            pup_hw_r <= 1'b1;
            pup_hw_on_r <= 1'b1;
            host_r <= 1'b0;
            hnp_r <= UOC_HNP_A_PERI;
          end
        end
        UOC_HNP_A_PERI: begin
          if (idle_r > IDLEA_CYC) begin
            pup_hw_on_r <= 1'b0;
            hcnt_r <= 32'h0000_0000;
            hnp_r <= UOC_HNP_A_SETTLE;
          end
        end
        UOC_HNP_A_SETTLE: begin
          if (hcnt_r >= SETTLE_CYC && j_s) begin
            host_r <= 1'b1;
            hnp_r <= UOC_HNP_IDLE;
          end
        end
        default: hnp_r <= UOC_HNP_IDLE;
      endcase
      if (!svalid_s && is_a && !ctrl_r[`UOC_CTL_BUSDRV]) begin
        hnp_r <= UOC_HNP_IDLE; // session over, both idle
      end
    end
  end

  // peripheral suspend flag toggles on entry to 3 ms idle
  logic idle3_d_r;
  always_ff @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      pevt_r <= 16'h0000;
      idle3_d_r <= 1'b0;
    end else begin
      idle3_d_r <= idle3_r;
      pevt_r <= setclr(pevt_r, wr_pevt, set_h, clr_h);
      if (!host_r && idle3_r && !idle3_d_r && pevten_r[`UOC_PE_SUSP]) begin
        pevt_r[`UOC_PE_SUSP] <= !pevt_r[`UOC_PE_SUSP];
      end
    end
  end

  // pin outputs, all registered
  always_ff @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      o_data_plus_pull_up <= 1'b0;
      o_bus_power_charge <= 1'b0;
      o_bus_power_drain <= 1'b0;
      o_charge_pump_en <= 1'b0;
      o_bus_reset_drive <= 1'b0;
      o_host_role <= 1'b0;
    end else begin
      o_data_plus_pull_up <= (srp_r == UOC_SRP_DP)
          || (pup_hw_r ? pup_hw_on_r : ctrl_r[`UOC_CTL_PULLUP]);
      o_bus_power_charge <= !is_a && (srp_r == UOC_SRP_VB);
      o_bus_power_drain <= srp_r == UOC_SRP_DRAIN;
      o_charge_pump_en <= is_a && ctrl_r[`UOC_CTL_BUSDRV];
      o_bus_reset_drive <= host_r && ctrl_r[`UOC_CTL_DRVRST];
      o_host_role <= host_r;
    end
  end

  // read channel
  logic [31:0] rd_v;
  always_comb begin
    case (i_araddr)
      `UOC_OFF_CTRL: rd_v = {16'h0000, ctrl_r};
      `UOC_OFF_STAT: rd_v = {16'h0000, stat_v};
      `UOC_OFF_LATCH: rd_v = {16'h0000, latch_r};
      `UOC_OFF_ENFALL: rd_v = {16'h0000, enf_r};
      `UOC_OFF_ENRISE: rd_v = {16'h0000, enr_r};
      `UOC_OFF_TIMER: rd_v = tmr_cnt_r;
      `UOC_OFF_PEVT: rd_v = {16'h0000, pevt_r};
      `UOC_OFF_PEVTEN: rd_v = {16'h0000, pevten_r};
      default: rd_v = 32'h0000_0000;
    endcase
  end
  always_ff @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      o_rvalid <= 1'b0;
      o_rdata <= 32'h0000_0000;
    end else if (i_arvalid && o_arready) begin
      o_rvalid <= 1'b1;
      o_rdata <= rd_v;
    end else if (o_rvalid && i_rready) begin
      o_rvalid <= 1'b0;
    end
  end
  assign o_arready = !o_rvalid;
  assign o_rresp = 2'h0;

endmodule // uoc_top

// [tb/uoc_top_asserts.sv]
// Purpose: port checks for the otg session control block
// Assumes: sees top ports only, counts shortened by parameters
// Notes: pulse widths allow two cycles of slack
`timescale 1ns/1ns
module uoc_top_asserts #(
  parameter int unsigned VB_CYC = 100,
  parameter int unsigned DRAIN_CYC = 100
) (
  // clock and reset
  input wire logic i_core_clk,
  input wire logic i_rst,
  // bus handshake
  input wire logic i_rready,
  input wire logic i_bready,
  input wire logic o_arready,
  input wire logic [31:0] o_rdata,
  input wire logic [1:0] o_bresp,
  input wire logic o_bvalid,
  input wire logic o_rvalid,
  // role and supply
  input wire logic i_plug_type_sense,
  input wire logic o_bus_power_charge,
  input wire logic o_bus_power_drain,
  input wire logic o_charge_pump_en
);
  logic [31:0] ch_cnt_r;
  logic [31:0] dr_cnt_r;
  default clocking cb @(posedge i_core_clk); endclocking
  default disable iff (i_rst);
  // high-time counters, zeroed when the output drops
  always_ff @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) ch_cnt_r <= 32'h0;
    else ch_cnt_r <= o_bus_power_charge ? ch_cnt_r + 32'h1 : 32'h0;
  end
  always_ff @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) dr_cnt_r <= 32'h0;
    else dr_cnt_r <= o_bus_power_drain ? dr_cnt_r + 32'h1 : 32'h0;
  end
  property p_charge_len;
    $fell(o_bus_power_charge) |->
      (ch_cnt_r + 32'h2 >= VB_CYC) && (ch_cnt_r <= VB_CYC + 32'h2);
  endproperty
  a_charge_len: assert property (p_charge_len)
    else $error("supply charge pulse width off");
  property p_drain_len;
    $fell(o_bus_power_drain) |->
      (dr_cnt_r + 32'h2 >= DRAIN_CYC) && (dr_cnt_r <= DRAIN_CYC + 32'h2);
  endproperty
  a_drain_len: assert property (p_drain_len)
    else $error("supply drain width off");
  // sync latency is three cycles, so six gives margin
  property p_no_pump_b;
    i_plug_type_sense [*6] |-> !o_charge_pump_en;
  endproperty
  a_no_pump_b: assert property (p_no_pump_b)
    else $error("pump on while b side");
  property p_no_charge_a;
    !i_plug_type_sense [*6] |-> !o_bus_power_charge;
  endproperty
  a_no_charge_a: assert property (p_no_charge_a)
    else $error("charge pulse while a side");
  property p_charge_drain;
    o_bus_power_drain |-> !o_bus_power_charge;
  endproperty
  a_charge_drain: assert property (p_charge_drain)
    else $error("charge and drain together");
  property p_bresp_ok;
    o_bvalid |-> o_bresp == 2'h0;
  endproperty
  a_bresp_ok: assert property (p_bresp_ok)
    else $error("write response not okay");
  property p_bvalid_hold;
    o_bvalid && !i_bready |=> o_bvalid;
  endproperty
  a_bvalid_hold: assert property (p_bvalid_hold)
    else $error("write response dropped early");
  property p_rvalid_hold;
    o_rvalid && !i_rready |=> o_rvalid && $stable(o_rdata);
  endproperty
  a_rvalid_hold: assert property (p_rvalid_hold)
    else $error("read data not held");
  property p_ar_block;
    o_rvalid |-> !o_arready;
  endproperty
  a_ar_block: assert property (p_ar_block)
    else $error("address taken while read pending");
endmodule // uoc_top_asserts

bind uoc_top uoc_top_asserts #(.VB_CYC(VB_CYC), .DRAIN_CYC(DRAIN_CYC)) u_chk (
  .i_core_clk(i_core_clk),
  .i_rst(i_rst),
  .i_rready(i_rready),
  .i_bready(i_bready),
  .o_arready(o_arready),
  .o_rdata(o_rdata),
  .o_bresp(o_bresp),
  .o_bvalid(o_bvalid),
  .o_rvalid(o_rvalid),
  .i_plug_type_sense(i_plug_type_sense),
  .o_bus_power_charge(o_bus_power_charge),
  .o_bus_power_drain(o_bus_power_drain),
  .o_charge_pump_en(o_charge_pump_en)
);

// [tb/uoc_remote_model.sv]
// Purpose: remote usb device seen across the port
// Assumes: line pull-downs give se0 when nobody pulls up
// Notes: behavioural, reacts with no delay
`timescale 1ns/1ns
module uoc_remote_model (
  // block outputs seen on the cable
  input wire logic i_pump,
  input wire logic i_pull_up,
  input wire logic i_reset_drive,
  // scenario controls
  input wire logic i_rem_vbus,
  input wire logic i_rem_conn,
  input wire logic i_rem_pulse,
  input wire logic i_rem_busy,
  // line levels back to the block
  output logic o_sess_valid,
  output logic o_sess_end,
  output logic o_dp,
  output logic o_dm,
  output logic o_activity
);
  logic rem_pu;
  // supply valid from the block's pump or the remote's supply
  assign o_sess_valid = i_pump || i_rem_vbus;
  assign o_sess_end = !o_sess_valid;
  // remote pulls up when connected on valid supply, or pulses for a request
  assign rem_pu = i_rem_pulse || (i_rem_conn && o_sess_valid);
  // a driven reset wins over any pull-up
  assign o_dp = (rem_pu || i_pull_up) && !i_reset_drive;
  assign o_dm = 1'b0;
  assign o_activity = i_rem_busy;
endmodule // uoc_remote_model

// [tb/uoc_top_tb_top.sv]
// Purpose: directed bench for the otg session control block
// Assumes: shortened counts, registers at config header offsets
// Notes: pulse counts sampled on falling edges
`timescale 1ns/1ns
`include "uoc_cfg.svh"
module uoc_top_tb_top;
  localparam int DPC = 100;
  localparam int VBC = 200;
  localparam int DRC = 300;
  localparam int MAXC = 1000;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic [11:0] awaddr = 12'h000, araddr = 12'h000;
  logic [31:0] wdata = 32'h0;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
  logic arvalid = 1'b0, rready = 1'b0, busy = 1'b0;
  logic plug = 1'b1, rem_vbus = 1'b0, rem_conn = 1'b0, rem_pulse = 1'b0;
  logic awready, wready, bvalid, arready, rvalid;
  logic [1:0] bresp, rresp;
  logic [31:0] rdata;
  logic pull_up, charge, drain, pump, rst_drv, host;
  logic sv, se, dp, dm, act;
  int err_total = 0, samples_checked = 0;
  int tick, npu, nch, ndr, lpu, fch, lch;

  uoc_top #(.DP_CYC(DPC), .VB_CYC(VBC), .DRAIN_CYC(DRC),
    .SRPMAX_CYC(MAXC), .IDLEB_CYC(150), .IDLEA_CYC(150),
    .SETTLE_CYC(10), .TICK_CYC(4)) dut (
    .i_core_clk(clk), .i_rst(rst),
    .i_awaddr(awaddr), .i_awvalid(awvalid), .o_awready(awready),
    .i_wdata(wdata), .i_wstrb(4'hF), .i_wvalid(wvalid),
    .o_wready(wready), .o_bresp(bresp), .o_bvalid(bvalid),
    .i_bready(bready), .i_araddr(araddr), .i_arvalid(arvalid),
    .o_arready(arready), .o_rdata(rdata), .o_rresp(rresp),
    .o_rvalid(rvalid), .i_rready(rready),
    .i_plug_type_sense(plug), .i_sess_valid(sv), .i_sess_end(se),
    .i_line_dp(dp), .i_line_dm(dm), .i_bus_activity(act),
    .o_data_plus_pull_up(pull_up), .o_bus_power_charge(charge),
    .o_bus_power_drain(drain), .o_charge_pump_en(pump),
    .o_bus_reset_drive(rst_drv), .o_host_role(host));

  uoc_remote_model u_rem (
    .i_pump(pump), .i_pull_up(pull_up), .i_reset_drive(rst_drv),
    .i_rem_vbus(rem_vbus), .i_rem_conn(rem_conn),
    .i_rem_pulse(rem_pulse), .i_rem_busy(busy),
    .o_sess_valid(sv), .o_sess_end(se), .o_dp(dp), .o_dm(dm),
    .o_activity(act));

  always #20 clk = ~clk;
  // pulse widths and order, away from the sampling edge
  always @(negedge clk) begin
    tick++;
    if (pull_up) begin npu++; lpu = tick; end
    if (charge) begin nch++; lch = tick; if (fch == 0) fch = tick; end
    if (drain) ndr++;
  end

  task automatic clr_cnt;
    tick = 0; npu = 0; nch = 0; ndr = 0; lpu = 0; fch = 0; lch = 0;
  endtask
  task automatic cmp(input logic [31:0] got, input logic [31:0] exp,
                     input string what);
    samples_checked++;
    if (got !== exp) begin
      err_total++;
      $display("[ERR] %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask
  task automatic cmp_rng(input int got, input int lo, input int hi);
    samples_checked++;
    if (got < lo || got > hi) begin
      err_total++;
      $display("[ERR] %0t count %0d not in %0d..%0d", $time, got, lo, hi);
    end
  endtask
  // write: both channels offered, each dropped once taken
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    logic ad;
    logic wd;
    ad = 1'b0;
    wd = 1'b0;
    @(posedge clk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    while (!(ad && wd)) begin
      @(negedge clk);
      if (awready === 1'b1) ad = 1'b1;
      if (wready === 1'b1) wd = 1'b1;
      @(posedge clk);
      if (ad) awvalid <= 1'b0;
      if (wd) wvalid <= 1'b0;
    end
    do @(negedge clk); while (bvalid !== 1'b1);
    @(posedge clk);
    bready <= 1'b0;
  endtask
  // read: ready raised late so the data must stand
  task automatic rd(input logic [11:0] a, output logic [31:0] d);
    @(posedge clk);
    araddr <= a;
    arvalid <= 1'b1;
    do @(negedge clk); while (arready !== 1'b1);
    @(posedge clk);
    arvalid <= 1'b0;
    do @(negedge clk); while (rvalid !== 1'b1);
    d = rdata;
    @(posedge clk);
    rready <= 1'b1;
    @(posedge clk);
    rready <= 1'b0;
  endtask
  task automatic pulse(input logic on_dp);
    @(posedge clk);
    if (on_dp) rem_pulse <= 1'b1;
    else rem_vbus <= 1'b1;
    repeat (20) @(posedge clk);
    rem_pulse <= 1'b0;
    rem_vbus <= 1'b0;
    repeat (10) @(posedge clk);
  endtask

  task automatic t_regs;
    logic [31:0] d;
    cmp({26'h0, pull_up, charge, drain, pump, rst_drv, host}, 32'h0,
        "idle outputs");
    wr(`UOC_OFF_CTRL, 32'h0000_0001);
    rd(`UOC_OFF_CTRL, d);
    cmp(d & 32'h1, 32'h1, "set half");
    cmp({31'h0, pull_up}, 32'h1, "pull-up pin");
    wr(`UOC_OFF_CTRL, 32'h0001_0000);
    rd(`UOC_OFF_CTRL, d);
    cmp(d & 32'h1, 32'h0, "clear half");
    wr(12'h100, 32'hFFFF_FFFF);
    rd(12'h100, d);
    cmp(d, 32'h0, "unmapped");
    $display("test regs done");
  endtask
  task automatic t_role;
    logic [31:0] d;
    wr(`UOC_OFF_CTRL, 32'h0000_0200);
    repeat (10) @(posedge clk);
    cmp({31'h0, pump}, 32'h0, "b pump");
    cmp({31'h0, host}, 32'h0, "b role");
    rd(`UOC_OFF_STAT, d);
    cmp(d & 32'h1, 32'h1, "plug b");
    wr(`UOC_OFF_CTRL, 32'h0200_0000);
    @(posedge clk);
    plug <= 1'b0;
    rem_conn <= 1'b1;
    repeat (10) @(posedge clk);
    rd(`UOC_OFF_STAT, d);
    cmp(d & 32'h1, 32'h0, "plug a");
    wr(`UOC_OFF_CTRL, 32'h0000_0200);
    // margin covers sync, settle and register delay
    repeat (40) @(posedge clk);
    cmp({31'h0, pump}, 32'h1, "a pump");
    cmp({31'h0, host}, 32'h1, "a host");
    wr(`UOC_OFF_CTRL, 32'h0200_0000);
    repeat (10) @(posedge clk);
    cmp({31'h0, pump}, 32'h0, "pump off");
    plug <= 1'b1;
    rem_conn <= 1'b0;
    repeat (10) @(posedge clk);
    $display("test role done");
  endtask
  task automatic t_srp;
    logic [31:0] d;
    clr_cnt();
    wr(`UOC_OFF_CTRL, 32'h0000_0120);
    repeat (MAXC) @(posedge clk);
    cmp_rng(npu, DPC - 2, DPC + 2);
    cmp_rng(nch, VBC - 2, VBC + 2);
    cmp_rng(fch - lpu, 1, MAXC);
    cmp_rng(ndr, DRC - 2, DRC + 2);
    cmp_rng(lch, 1, MAXC);
    rd(`UOC_OFF_STAT, d);
    cmp((d >> 9) & 32'h3, 32'h1, "request done");
    wr(`UOC_OFF_CTRL, 32'h0020_0000);
    @(posedge clk);
    rem_vbus <= 1'b1;
    repeat (10) @(posedge clk);
    clr_cnt();
    wr(`UOC_OFF_CTRL, 32'h0000_0100);
    repeat (DPC) @(posedge clk);
    cmp_rng(npu + nch, 0, 0);
    rd(`UOC_OFF_STAT, d);
    cmp((d >> 10) & 32'h1, 32'h1, "refused");
    rem_vbus <= 1'b0;
    $display("test session request done");
  endtask
  task automatic t_detect;
    logic [31:0] d;
    plug <= 1'b0;
    repeat (10) @(posedge clk);
    wr(`UOC_OFF_LATCH, 32'hFFFF_0000);
    pulse(1'b0);
    rd(`UOC_OFF_LATCH, d);
    cmp(d & 32'h6, 32'h0, "masked");
    wr(`UOC_OFF_ENFALL, 32'h0000_0002);
    wr(`UOC_OFF_ENRISE, 32'h0000_0006);
    pulse(1'b0);
    rd(`UOC_OFF_LATCH, d);
    cmp(d & 32'h6, 32'h2, "supply request");
    wr(`UOC_OFF_LATCH, 32'hFFFF_0000);
    pulse(1'b1);
    rd(`UOC_OFF_LATCH, d);
    cmp(d & 32'h6, 32'h4, "line request");
    wr(`UOC_OFF_ENFALL, 32'h0002_0000);
    wr(`UOC_OFF_ENRISE, 32'h0006_0000);
    wr(`UOC_OFF_LATCH, 32'hFFFF_0000);
    wr(`UOC_OFF_TIMER, 32'h0000_0005);
    rd(`UOC_OFF_LATCH, d);
    cmp(d & 32'h10, 32'h0, "timer early");
    repeat (40) @(posedge clk);
    rd(`UOC_OFF_LATCH, d);
    cmp(d & 32'h10, 32'h10, "timer out");
    $display("test detect and timer done");
  endtask
  task automatic t_hnp;
    logic [31:0] d;
    wr(`UOC_OFF_PEVTEN, 32'h0000_0001);
    wr(`UOC_OFF_CTRL, 32'h0000_0200);
    busy <= 1'b1;
    wr(`UOC_OFF_CTRL, 32'h0000_1000);
    repeat (20) @(posedge clk);
    cmp({30'h0, pull_up, host}, 32'h2, "a yields");
    repeat (200) @(posedge clk);
    cmp({31'h0, pull_up}, 32'h1, "busy holds");
    busy <= 1'b0;
    repeat (200) @(posedge clk);
    cmp({31'h0, pull_up}, 32'h0, "idle drop");
    rd(`UOC_OFF_PEVT, d);
    cmp(d & 32'h1, 32'h1, "suspend toggle");
    rem_conn <= 1'b1;
    repeat (30) @(posedge clk);
    cmp({31'h0, host}, 32'h1, "a resumes");
    $display("test hand-off done");
  endtask

  task automatic report_and_stop;
    $display("checked %0d mismatches %0d", samples_checked, err_total);
    if (err_total == 0 && samples_checked > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  // main sequence
  initial begin
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    t_regs();
    t_role();
    t_srp();
    t_detect();
    t_hnp();
    report_and_stop();
  end
  // watchdog well past the expected few thousand cycles
  initial begin
    repeat (20000) @(posedge clk);
    err_total++;
    $display("[ERR] %0t watchdog expired", $time);
    report_and_stop();
  end
endmodule // uoc_top_tb_top
